// file: core/dsr_pkg.sv
// Constants and types shared by the display status read-back block
package dsr_pkg;

    // Command codes answered by the read-back interpreter
    localparam logic [7:0] DSR_CMD_DISPLAY_STATUS = 8'h09;
    localparam logic [7:0] DSR_CMD_POWER_MODE     = 8'h0A;
    localparam logic [7:0] DSR_CMD_ORIENTATION    = 8'h0B;
    localparam logic [7:0] DSR_CMD_PIXEL_FORMAT   = 8'h0C;
    localparam logic [7:0] DSR_CMD_IMAGE_FORMAT   = 8'h0D;

    // Reset values of the status snapshots and interpreter registers, plus the pixel format write mask
    localparam logic [7:0] DSR_POWER_MODE_RESET   = 8'h08;
    localparam logic [7:0] DSR_ORIENT_RESET       = 8'h00;
    localparam logic [7:0] DSR_IMAGE_RESET        = 8'h00;
    localparam logic [7:0] DSR_TAIL_RESET         = 8'h00;
    localparam logic [7:0] DSR_PIXFMT_HW_RESET    = 8'h06;
    localparam logic [7:0] DSR_PIXFMT_MASK        = 8'h77;
    localparam logic [7:0] DSR_DUMMY_FILL         = 8'h00;
    localparam logic [7:0] DSR_CMD_RESET          = 8'h00;

    // Pixel format and gamma encodings
    localparam logic [2:0] DSR_PIXFMT_16BPP       = 3'h5;
    localparam logic [2:0] DSR_PIXFMT_18BPP       = 3'h6;
    localparam logic [2:0] DSR_GAMMA_CURVE1       = 3'h0;
    localparam logic [2:0] DSR_GAMMA_CURVE2       = 3'h1;
    localparam logic [2:0] DSR_GAMMA_CURVE3       = 3'h2;
    localparam logic [2:0] DSR_GAMMA_CURVE4       = 3'h3;

    // Tearing output mode encodings
    localparam logic       DSR_TEAR_VBLANK_ONLY   = 1'b0;
    localparam logic       DSR_TEAR_HV_BLANK      = 1'b1;

    // Parameter indices
    localparam logic [2:0] DSR_IDX_FIRST          = 3'h0;
    localparam logic [2:0] DSR_IDX_STEP           = 3'h1;
    localparam logic [2:0] DSR_LAST_POWER         = 3'h0;
    localparam logic [2:0] DSR_LAST_SHORT         = 3'h1;
    localparam logic [2:0] DSR_LAST_STATUS        = 3'h4;

    // Interpreter states
    typedef enum logic [2:0] {
        DSR_IDLE  = 3'b001,
        DSR_ARMED = 3'b010,
        DSR_DRIVE = 3'b100
    } dsr_state_t;

endpackage

// file: core/dsr_sync.sv
// Multi-bit two-stage synchroniser for the host bus pins
`timescale 1ns/1ns
`default_nettype none

module dsr_sync #(
    parameter int          WIDTH       = 11,
    parameter int          STAGES      = 2,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_reg [STAGES];

    // Refused at elaboration: one stage would not settle a metastable edge
    if (STAGES < 2 || WIDTH < 1) begin : g_bad_shape
        $error("dsr_sync needs at least two stages and one bit");
    end

    // First stage feeds only the next stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= RESET_VALUE;
            end
        end else begin
            stage_reg[0] <= async_in;
            for (int i = 1; i < STAGES; i++) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign sync_out = stage_reg[STAGES-1];

endmodule

`default_nettype wire

// file: core/dsr_readback.sv
// Display status read-back command interpreter on the parallel host bus
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Tearing mode one: both blankings; low nibble zero
// - Tearing mode zero: vertical blanking only
// - Command 0Ah returns power byte next read
// - Power bit 7 only when booster good
// - Power bits 6..2 show live mode states
// - Command 0Bh returns orientation status byte
// - Orientation bit 7 mirrors row order
// - Orientation bit 6 mirrors column order
// - Orientation bit 5 mirrors row/column exchange
// - Orientation bit 4 mirrors vertical refresh
// - Orientation bit 3 mirrors colour order
// - Orientation bit 2 mirrors horizontal refresh
// - Low two bits always read zero
// - Dummy first read before meaningful byte, except 0Ah
// - 0Ch pixel format; hardware reset only
// - Format 101 sixteen, 110 eighteen bits
// - 0Dh gamma in low bits, upper zero
// - Gamma codes select curves one to four
// - Reads answered in every power mode
module dsr_readback #(
    parameter int DATA_WIDTH = 8,
    parameter int IDX_WIDTH  = 3
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  sw_reset,
    input  wire logic                  data_command_select,
    input  wire logic                  write_strobe_n,
    input  wire logic                  read_strobe_n,
    input  wire logic [DATA_WIDTH-1:0] data_in,
    output logic      [DATA_WIDTH-1:0] data_out,
    output logic                       data_oe,
    input  wire logic                  booster_on,
    input  wire logic                  booster_fault,
    input  wire logic                  idle_mode,
    input  wire logic                  partial_mode,
    input  wire logic                  sleep_out,
    input  wire logic                  normal_mode,
    input  wire logic                  display_on,
    input  wire logic                  tear_enable,
    input  wire logic                  tear_mode,
    input  wire logic [7:0]            memory_access_orientation,
    input  wire logic [2:0]            gamma_select,
    input  wire logic                  pixel_format_wr,
    input  wire logic [7:0]            pixel_format_wdata,
    output logic      [7:0]            pixel_format,
    output logic      [7:0]            display_status_tail,
    output logic      [7:0]            command_code,
    output logic                       read_busy
);

    localparam int PIN_WIDTH = DATA_WIDTH + 3;
    localparam logic [PIN_WIDTH-1:0] PIN_IDLE = {3'h7, {DATA_WIDTH{1'b0}}};

    // Byte picking and parameter counting are written for these widths only
    if (DATA_WIDTH != 8) begin : g_bad_data_width
        $error("dsr_readback serves only an 8-bit data bus");
    end
    if (IDX_WIDTH != 3) begin : g_bad_idx_width
        $error("dsr_readback needs a 3-bit parameter index");
    end

    // Synchronised pins
    logic [PIN_WIDTH-1:0] pins_sync;
    logic                 dcx_s;
    logic                 wr_s;
    logic                 rd_s;
    logic [7:0]           din_s;
    logic                 wr_d_reg;
    logic                 rd_d_reg;

    // Strobe events
    logic                 wr_rise;
    logic                 rd_fall;
    logic                 rd_rise;
    logic                 cmd_take;
    logic                 cmd_is_read;
    logic                 rd_cycle;

    // Status snapshots
    logic [7:0]           power_mode_status_reg;
    logic [7:0]           power_mode_status_next;
    logic [7:0]           orientation_readback_reg;
    logic [7:0]           orientation_readback_next;
    logic [7:0]           gamma_image_format_status_reg;
    logic [7:0]           gamma_image_format_status_next;
    logic [7:0]           display_status_tail_reg;
    logic [7:0]           display_status_tail_next;
    logic [7:0]           status_word1;
    logic [7:0]           status_word2;
    logic [7:0]           status_word3;
    logic [7:0]           pixel_format_reg;
    logic [7:0]           pixel_format_next;

    // Interpreter
    dsr_pkg::dsr_state_t  state_reg;
    dsr_pkg::dsr_state_t  state_next;
    logic [7:0]           cmd_reg;
    logic [7:0]           cmd_next;
    logic [2:0]           idx_reg;
    logic [2:0]           idx_next;
    logic [7:0]           data_out_reg;
    logic [7:0]           data_out_next;
    logic [7:0]           picked_byte;
    logic                 last_param;

    // True for every command this block answers
    function automatic logic dsr_is_read(input logic [7:0] cmd);
        dsr_is_read = (cmd == dsr_pkg::DSR_CMD_DISPLAY_STATUS)
                   || (cmd == dsr_pkg::DSR_CMD_POWER_MODE)
                   || (cmd == dsr_pkg::DSR_CMD_ORIENTATION)
                   || (cmd == dsr_pkg::DSR_CMD_PIXEL_FORMAT)
                   || (cmd == dsr_pkg::DSR_CMD_IMAGE_FORMAT);
    endfunction

    // Index of the final parameter of a read command
    function automatic logic [2:0] dsr_last_index(input logic [7:0] cmd);
        if (cmd == dsr_pkg::DSR_CMD_POWER_MODE) begin
            dsr_last_index = dsr_pkg::DSR_LAST_POWER;
        end else if (cmd == dsr_pkg::DSR_CMD_DISPLAY_STATUS) begin
            dsr_last_index = dsr_pkg::DSR_LAST_STATUS;
        end else begin
            dsr_last_index = dsr_pkg::DSR_LAST_SHORT;
        end
    endfunction

    // Byte returned for a command at a parameter index
    function automatic logic [7:0] dsr_pick(
        input logic [7:0] cmd,
        input logic [2:0] idx,
        input logic [7:0] pm,
        input logic [7:0] orb,
        input logic [7:0] pix,
        input logic [7:0] img,
        input logic [7:0] w1,
        input logic [7:0] w2,
        input logic [7:0] w3,
        input logic [7:0] w4
    );
        logic [7:0] b;
        b = dsr_pkg::DSR_DUMMY_FILL;
        if (cmd == dsr_pkg::DSR_CMD_POWER_MODE) begin
            b = pm;
        end else if (idx == dsr_pkg::DSR_IDX_FIRST) begin
            b = dsr_pkg::DSR_DUMMY_FILL;
        end else if (cmd == dsr_pkg::DSR_CMD_ORIENTATION) begin
            b = orb;
        end else if (cmd == dsr_pkg::DSR_CMD_PIXEL_FORMAT) begin
            b = pix;
        end else if (cmd == dsr_pkg::DSR_CMD_IMAGE_FORMAT) begin
            b = img;
        end else begin
            case (idx)
                3'h1:    b = w1;
                3'h2:    b = w2;
                3'h3:    b = w3;
                3'h4:    b = w4;
                default: b = dsr_pkg::DSR_DUMMY_FILL;
            endcase
        end
        dsr_pick = b;
    endfunction

    dsr_sync #(
        .WIDTH       (PIN_WIDTH),
        .STAGES      (2),
        .RESET_VALUE (PIN_IDLE)
    ) u_pin_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({data_command_select, write_strobe_n, read_strobe_n, data_in}),
        .sync_out (pins_sync)
    );

    assign dcx_s = pins_sync[DATA_WIDTH+2];
    assign wr_s  = pins_sync[DATA_WIDTH+1];
    assign rd_s  = pins_sync[DATA_WIDTH];
    assign din_s = pins_sync[DATA_WIDTH-1:0];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_d_reg <= 1'b1;
            rd_d_reg <= 1'b1;
        end else begin
            wr_d_reg <= wr_s;
            rd_d_reg <= rd_s;
        end
    end

    // Command byte on rising write strobe with select low
    assign wr_rise     = wr_s & ~wr_d_reg;
    assign rd_fall     = ~rd_s & rd_d_reg;
    assign rd_rise     = rd_s & ~rd_d_reg;
    assign cmd_take    = wr_rise & ~dcx_s;
    assign rd_cycle    = rd_fall & dcx_s & wr_s;
    assign cmd_is_read = dsr_is_read(din_s);

    // Live status, no gating on sleep, idle or partial state
    assign power_mode_status_next = {booster_on & ~booster_fault,
                                     idle_mode,
                                     partial_mode,
                                     sleep_out,
                                     normal_mode,
                                     display_on,
                                     2'b00};
    assign orientation_readback_next = {memory_access_orientation[7],
                                        memory_access_orientation[6],
                                        memory_access_orientation[5],
                                        memory_access_orientation[4],
                                        memory_access_orientation[3],
                                        memory_access_orientation[2],
                                        2'b00};
    assign gamma_image_format_status_next = {5'h00, gamma_select};
    // Tearing mode bit: one both blankings, zero vertical only
    assign display_status_tail_next = {gamma_select[1:0], tear_mode, 5'h00};
    assign status_word1 = {power_mode_status_reg[7], orientation_readback_reg[7:2], 1'b0};
    assign status_word2 = {1'b0, pixel_format_reg[2:0], idle_mode, partial_mode,
                           sleep_out, normal_mode};
    assign status_word3 = {5'h00, display_on, tear_enable, gamma_select[2]};

    // Format field keeps 101 and 110 as written; reserved bits masked
    assign pixel_format_next = pixel_format_wr ? (pixel_format_wdata & dsr_pkg::DSR_PIXFMT_MASK)
                                               : pixel_format_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_mode_status_reg         <= dsr_pkg::DSR_POWER_MODE_RESET;
            orientation_readback_reg      <= dsr_pkg::DSR_ORIENT_RESET;
            gamma_image_format_status_reg <= dsr_pkg::DSR_IMAGE_RESET;
            display_status_tail_reg       <= dsr_pkg::DSR_TAIL_RESET;
        end else begin
            power_mode_status_reg         <= power_mode_status_next;
            orientation_readback_reg      <= orientation_readback_next;
            gamma_image_format_status_reg <= gamma_image_format_status_next;
            display_status_tail_reg       <= display_status_tail_next;
        end
    end

    // Hardware reset only; software reset leaves the format alone
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pixel_format_reg <= dsr_pkg::DSR_PIXFMT_HW_RESET;
        end else begin
            pixel_format_reg <= pixel_format_next;
        end
    end

    assign picked_byte = dsr_pick(cmd_reg, idx_reg,
                                  power_mode_status_reg,
                                  orientation_readback_reg,
                                  pixel_format_reg,
                                  gamma_image_format_status_reg,
                                  status_word1, status_word2, status_word3,
                                  display_status_tail_reg);
    assign last_param  = (idx_reg >= dsr_last_index(cmd_reg));

    // Command decode is independent of power mode
    always_comb begin
        state_next    = state_reg;
        cmd_next      = cmd_reg;
        idx_next      = idx_reg;
        data_out_next = data_out_reg;
        if (sw_reset) begin
            state_next = dsr_pkg::DSR_IDLE;
            idx_next   = dsr_pkg::DSR_IDX_FIRST;
        end else if (cmd_take) begin
            cmd_next   = din_s;
            idx_next   = dsr_pkg::DSR_IDX_FIRST;
            state_next = cmd_is_read ? dsr_pkg::DSR_ARMED : dsr_pkg::DSR_IDLE;
        end else begin
            case (state_reg)
                dsr_pkg::DSR_IDLE: begin
                    state_next = dsr_pkg::DSR_IDLE;
                end
                dsr_pkg::DSR_ARMED: begin
                    if (rd_cycle) begin
                        data_out_next = picked_byte;
                        state_next    = dsr_pkg::DSR_DRIVE;
                    end
                end
                dsr_pkg::DSR_DRIVE: begin
                    if (rd_rise) begin
                        if (last_param) begin
                            state_next = dsr_pkg::DSR_IDLE;
                        end else begin
                            idx_next   = idx_reg + dsr_pkg::DSR_IDX_STEP;
                            state_next = dsr_pkg::DSR_ARMED;
                        end
                    end
                end
                default: begin
                    state_next = dsr_pkg::DSR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= dsr_pkg::DSR_IDLE;
            cmd_reg      <= dsr_pkg::DSR_CMD_RESET;
            idx_reg      <= dsr_pkg::DSR_IDX_FIRST;
            data_out_reg <= dsr_pkg::DSR_DUMMY_FILL;
        end else begin
            state_reg    <= state_next;
            cmd_reg      <= cmd_next;
            idx_reg      <= idx_next;
            data_out_reg <= data_out_next;
        end
    end

    // Bus driven from an answered read strobe until its synchronised release is seen
    assign data_out            = data_out_reg;
    assign data_oe             = (state_reg == dsr_pkg::DSR_DRIVE);
    assign read_busy           = (state_reg != dsr_pkg::DSR_IDLE);
    assign pixel_format        = pixel_format_reg;
    assign display_status_tail = display_status_tail_reg;
    assign command_code        = cmd_reg;

endmodule

`default_nettype wire

// file: bench/dsr_host_model.sv
// Host side model driving the parallel command bus strobes
`timescale 1ns/1ns
`default_nettype none

module dsr_host_model (
    input  wire logic       clk,
    input  wire logic       data_oe,
    input  wire logic [7:0] data_out,
    output logic            data_command_select,
    output logic            write_strobe_n,
    output logic            read_strobe_n,
    output logic      [7:0] data_in
);
    // Strobe level length, raised by the bench for a slow host
    int strobe_cycles = 6;

    initial begin
        data_command_select = 1'b1;
        write_strobe_n      = 1'b1;
        read_strobe_n       = 1'b1;
        data_in             = 8'h00;
    end

    task automatic write_cmd(input logic [7:0] c);
        @(posedge clk);
        data_command_select <= 1'b0;
        data_in             <= c;
        write_strobe_n      <= 1'b0;
        repeat (strobe_cycles) @(posedge clk);
        write_strobe_n <= 1'b1;
        repeat (strobe_cycles) @(posedge clk);
        // Released bus shows the inverse of the last byte
        data_in <= ~c;
    endtask

    task automatic read_param(output logic [7:0] d, output logic got);
        got = 1'b0;
        d   = 8'h00;
        @(posedge clk);
        data_command_select <= 1'b1;
        read_strobe_n       <= 1'b0;
        repeat (strobe_cycles + 2) begin
            @(negedge clk);
            if (data_oe === 1'b1 && got === 1'b0) begin
                d   = data_out;
                got = 1'b1;
            end
        end
        @(posedge clk);
        read_strobe_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// file: bench/dsr_readback_asserts.sv
// Concurrent checks on the display status read-back ports
`timescale 1ns/1ns
`default_nettype none

module dsr_readback_asserts (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       read_strobe_n,
    input wire logic       tear_mode,
    input wire logic [2:0] gamma_select,
    input wire logic       pixel_format_wr,
    input wire logic [7:0] pixel_format_wdata,
    input wire logic [7:0] pixel_format,
    input wire logic [7:0] display_status_tail,
    input wire logic [7:0] command_code,
    input wire logic       read_busy,
    input wire logic       data_oe,
    input wire logic [7:0] data_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence rd_released_s;
        read_strobe_n [*7];
    endsequence

    sequence drive_of_s(logic [7:0] c);
        data_oe && command_code == c;
    endsequence

    oe_busy_a: assert property (data_oe |-> read_busy)
        else $error("Bus driven with no read active");
    oe_answer_a: assert property ($rose(data_oe) |-> !$past(read_strobe_n, 2))
        else $error("Bus driven without a read strobe");
    oe_release_a: assert property (rd_released_s |-> !data_oe)
        else $error("Bus still driven after strobe release");
    busy_cmd_a: assert property ($rose(read_busy) |-> command_code inside {[8'h09:8'h0D]})
        else $error("Read started by a non-read command");
    power_low_a: assert property (drive_of_s(8'h0A) |-> data_out[1:0] == 2'b00)
        else $error("Power byte low bits not zero");
    orient_low_a: assert property (drive_of_s(8'h0B) |-> data_out[1:0] == 2'b00)
        else $error("Orientation byte low bits not zero");
    gamma_upper_a: assert property (drive_of_s(8'h0D) |-> data_out[7:3] == 5'h00)
        else $error("Image format upper bits not zero");
    tear_follow_a: assert property (!$past(sys_rst) |-> display_status_tail[5] == $past(tear_mode))
        else $error("Tail tearing mode bit wrong");
    tail_gamma_a: assert property (!$past(sys_rst) |->
        display_status_tail[7:6] == 2'($past(gamma_select)) && display_status_tail[4:0] == 5'h00)
        else $error("Tail gamma or unused bits wrong");
    pixfmt_load_a: assert property (pixel_format_wr |=>
        pixel_format == ($past(pixel_format_wdata) & 8'h77))
        else $error("Pixel format load wrong");
    pixfmt_hold_a: assert property (!pixel_format_wr |=> $stable(pixel_format))
        else $error("Pixel format changed without a load");
endmodule

bind dsr_readback dsr_readback_asserts u_asserts (
    .clk, .sys_rst, .read_strobe_n, .tear_mode, .gamma_select, .pixel_format_wr,
    .pixel_format_wdata, .pixel_format, .display_status_tail, .command_code, .read_busy,
    .data_oe, .data_out
);

`default_nettype wire

// file: bench/tb_dsr_readback.sv
// Self-checking testbench for the display status read-back block
`timescale 1ns/1ns
`default_nettype none

module tb_dsr_readback;
    logic       clk, sys_rst, sw_reset, data_command_select, write_strobe_n, read_strobe_n;
    logic       data_oe, booster_on, booster_fault, idle_mode, partial_mode, sleep_out;
    logic       normal_mode, display_on, tear_enable, tear_mode, pixel_format_wr, read_busy;
    logic [7:0] data_in, data_out, memory_access_orientation, pixel_format_wdata;
    logic [7:0] pixel_format, display_status_tail, command_code;
    logic [2:0] gamma_select;
    int         n_mismatch;
    int         n_compared;

    dsr_readback dut (
        .clk, .sys_rst, .sw_reset, .data_command_select, .write_strobe_n, .read_strobe_n,
        .data_in, .data_out, .data_oe, .booster_on, .booster_fault, .idle_mode, .partial_mode,
        .sleep_out, .normal_mode, .display_on, .tear_enable, .tear_mode,
        .memory_access_orientation, .gamma_select, .pixel_format_wr, .pixel_format_wdata,
        .pixel_format, .display_status_tail, .command_code, .read_busy
    );

    dsr_host_model host (
        .clk, .data_oe, .data_out, .data_command_select, .write_strobe_n, .read_strobe_n, .data_in
    );

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic expect_read(input logic [7:0] c, input bit dummy, input logic [7:0] exp);
        logic [7:0] d;
        logic       got;
        host.write_cmd(c);
        check8(command_code, c);
        check8({7'h00, read_busy}, 8'h01);
        if (dummy) host.read_param(d, got);
        host.read_param(d, got);
        check8({7'h00, got}, 8'h01);
        check8(d, exp);
        check8({7'h00, read_busy}, 8'h00);
    endtask

    task automatic test_power();
        logic [6:0] v [5] = '{7'h5F, 7'h7F, 7'h00, 7'h55, 7'h2A};
        foreach (v[i]) begin
            @(posedge clk);
            {booster_on, booster_fault, idle_mode, partial_mode, sleep_out, normal_mode,
             display_on} <= v[i];
            expect_read(8'h0A, 0, {v[i][6] & ~v[i][5], v[i][4:0], 2'b00});
        end
    endtask

    task automatic test_orient();
        logic [7:0] o;
        for (int i = 0; i < 7; i++) begin
            o = (i < 6) ? (8'h80 >> i) : 8'hFF;
            @(posedge clk);
            memory_access_orientation <= o;
            expect_read(8'h0B, 1, o & 8'hFC);
        end
    endtask

    task automatic test_refused();
        logic [7:0] d;
        logic       got;
        host.strobe_cycles = 12;
        host.write_cmd(8'h2C);
        check8(command_code, 8'h2C);
        check8({7'h00, read_busy}, 8'h00);
        host.read_param(d, got);
        check8({7'h00, got}, 8'h00);
        expect_read(8'h0A, 0, 8'h28);
        host.read_param(d, got);
        check8({7'h00, got}, 8'h00);
        host.strobe_cycles = 6;
    endtask

    task automatic test_pixfmt();
        expect_read(8'h0C, 1, 8'h06);
        @(posedge clk);
        pixel_format_wr    <= 1'b1;
        pixel_format_wdata <= 8'hFD;
        @(posedge clk);
        pixel_format_wr <= 1'b0;
        sw_reset        <= 1'b1;
        @(posedge clk);
        sw_reset <= 1'b0;
        expect_read(8'h0C, 1, 8'h75);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        expect_read(8'h0C, 1, 8'h06);
    endtask

    task automatic test_gamma();
        for (int g = 0; g < 4; g++) begin
            @(posedge clk);
            gamma_select <= 3'(g);
            tear_mode    <= ~g[0];
            tear_enable  <= g[1];
            expect_read(8'h0D, 1, 8'(g));
            check8(display_status_tail, {g[1:0], ~g[0], 5'h00});
        end
    endtask

    task automatic test_status();
        logic [7:0] d;
        logic       got;
        logic [7:0] w [5] = '{8'h00, 8'hD2, 8'h6A, 8'h07, 8'h60};
        @(posedge clk);
        {booster_on, booster_fault, idle_mode, partial_mode, sleep_out, normal_mode,
         display_on} <= 7'h55;
        memory_access_orientation <= 8'hA6;
        gamma_select              <= 3'h5;
        tear_enable               <= 1'b1;
        tear_mode                 <= 1'b1;
        host.write_cmd(8'h09);
        foreach (w[i]) begin
            host.read_param(d, got);
            check8({7'h00, got}, 8'h01);
            check8(d, w[i]);
        end
        host.read_param(d, got);
        check8({7'h00, got}, 8'h00);
    endtask

    task automatic finish_test();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        sw_reset = 1'b0;
        {booster_on, booster_fault, idle_mode, partial_mode} = 4'h0;
        {sleep_out, normal_mode, display_on, tear_enable, tear_mode} = 5'b01000;
        memory_access_orientation = 8'h00;
        gamma_select = 3'h0;
        pixel_format_wr = 1'b0;
        pixel_format_wdata = 8'h00;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        check8(pixel_format, 8'h06);
        expect_read(8'h0A, 0, 8'h08);
        test_power();
        test_orient();
        test_refused();
        test_pixfmt();
        test_gamma();
        test_status();
        finish_test();
    end
endmodule

`default_nettype wire
